// ===== shared/ims_pkg.sv
`default_nettype none
package ims_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCL_HALF_NS = 5000;
    localparam int SCL_HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
    // bit positions within a byte frame
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic ACK_LVL = 1'h0;
    localparam logic NACK_LVL = 1'h1;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    // interrupt vector offsets
    localparam logic [7:0] VEC_SLAVE = 8'h00;
    localparam logic [7:0] VEC_MASTER = 8'h02;
    // master command field
    localparam logic [1:0] CMD_NOACT = 2'h0;
    localparam logic [1:0] CMD_REPSTART = 2'h1;
    localparam logic [1:0] CMD_RECV = 2'h2;
    localparam logic [1:0] CMD_STOP = 2'h3;

    typedef enum logic [3:0] {
        MS_IDLE, MS_WAIT_IDLE, MS_START, MS_LOW, MS_HIGH, MS_HOLD,
        MS_RS_LOW, MS_RS_HIGH, MS_STOP_LOW, MS_STOP_HIGH, MS_LOST
    } ims_mstate_t;

    typedef enum logic [2:0] {
        SS_IDLE, SS_ADDR, SS_ACK, SS_RX, SS_TX, SS_TXACK, SS_HOLD
    } ims_sstate_t;

    typedef enum logic [1:0] {RES_ADDR, RES_RECEIVED_ACK_FLAG, RES_TX} ims_resume_t;

    typedef struct packed {
        logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
        logic bus_busy, scl_lo, sda_lo;
        logic [7:0] irq_vec;
        ims_mstate_t m_state;
        logic [CNT_W-1:0] m_cnt;
        logic [3:0] m_bit;
        logic [7:0] m_sh, m_addr, m_data;
        logic m_wr, m_addr_ph, m_dir, m_quick, m_after_stop, m_ack_bit;
        logic m_rif, m_wif, m_arb, m_berr, m_received_ack_flag;
        ims_sstate_t s_state;
        ims_resume_t s_resume;
        logic [3:0] s_bit;
        logic [7:0] s_sh, s_data;
        logic s_ack_bit, s_active, s_just_start;
        logic s_dif, s_slave_addr_stop_flag, s_ap, s_dir, s_coll, s_berr, s_received_ack_flag;
    } ims_state_t;
endpackage : ims_pkg
`default_nettype wire

// ===== logic/ims_top.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - arbitration lost in address: set write and lost flags, release lines, wait idle.
// - bus error in address: as arbitration loss plus bus error flag.
// - address NACK: set write flag, ack flag high, hold clock low.
// - address ACK with write direction: set write flag, clear ack flag, hold clock.
// - address ACK with read direction: receive byte, set read flag, hold clock.
// - a master read/write flag in MS_HOLD, or the slave in SS_HOLD, forces SCL low.
// - quick command: address only, read or write flag from direction bit.
// - after quick command a stop command issues a Stop.
// - slave compares address after Start; match stores it, else waits next Start.
// - slave address/stop flag set on matching address or general call.
// - address recognition mode answers every address.
// - Start followed directly by Stop sets slave bus error flag.
// - slave direction flag equals received read/write bit.
// - matched read: stretch, after ACK request transmit data, after NACK wait.
// - matched write: stretch, after ACK await data, after NACK wait.
// - slave collision: set flag, release outputs and clock, still accept Start.
// - Stop received after a matched address sets address/stop flag marked as stop.
// - each received byte sets data flag; after NACK expect Stop or Start.
// - slave sends written bytes, flags each; master NACK ends sending.
// - master smart mode: data read sends ACK only when action is ACK.
// - slave smart mode: data read or write clears slave data flag.
// - slave flags ORed to vector 0x00, master flags to vector 0x02.
// - clearing a master flag releases the clock stretch.
module ims_top
    import ims_pkg::*;
#(
    parameter int HALF_CYC = SCL_HALF_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic master_enable_i,
    input wire logic quick_command_enable_i,
    input wire logic smart_mode_enable_i,
    input wire logic acknowledge_action_i,
    input wire logic m_addr_wr_i,
    input wire logic [7:0] m_addr_i,
    input wire logic m_data_wr_i,
    input wire logic [7:0] m_data_i,
    input wire logic m_data_rd_i,
    input wire logic m_cmd_wr_i,
    input wire logic [1:0] m_cmd_i,
    input wire logic m_flag_clr_i,
    output logic [7:0] master_data_o,
    output logic master_read_flag_o,
    output logic master_write_flag_o,
    output logic arbitration_lost_flag_o,
    output logic bus_error_flag_o,
    output logic received_ack_flag_o,
    output logic bus_busy_o,
    input wire logic slave_enable_i,
    input wire logic [6:0] s_own_addr_i,
    input wire logic s_gen_call_en_i,
    input wire logic s_addr_recog_en_i,
    input wire logic s_smart_mode_enable_i,
    input wire logic s_acknowledge_action_i,
    input wire logic s_data_wr_i,
    input wire logic [7:0] s_data_i,
    input wire logic s_data_rd_i,
    input wire logic s_data_flag_clr_i,
    input wire logic s_addr_stop_flag_clr_i,
    input wire logic s_err_clr_i,
    output logic [7:0] slave_data_o,
    output logic slave_data_flag_o,
    output logic slave_addr_stop_flag_o,
    output logic s_addr_not_stop_o,
    output logic s_dir_o,
    output logic s_collision_o,
    output logic s_bus_error_o,
    output logic s_received_ack_o,
    output logic slave_irq_o,
    output logic master_irq_o,
    output logic [7:0] irq_vector_o
);
    localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(HALF_CYC - 1);

    ims_state_t r;
    ims_state_t n;
    logic scl_rise, scl_fall, start_det, stop_det, m_tick, m_go, m_rs_req, s_match;
    logic [7:0] m_new_addr;

    function automatic logic m_drives(input logic [3:0] b, input logic wr);
        m_drives = (b == BIT_ACK) ? ~wr : wr;
    endfunction : m_drives

    function automatic logic m_cur_bit(input logic [3:0] b, input logic [7:0] sh, input logic ab);
        m_cur_bit = (b == BIT_ACK) ? ab : sh[7];
    endfunction : m_cur_bit

    function automatic logic addr_match(input logic [7:0] a, input logic [6:0] own,
                                        input logic gc, input logic any);
        addr_match = any || (a[7:1] == own) || (gc && a[7:1] == GEN_CALL_ADDR);
    endfunction : addr_match

    assign scl_rise = r.scl_s2 & ~r.scl_d;
    assign scl_fall = ~r.scl_s2 & r.scl_d;
    assign start_det = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    assign stop_det = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
    assign m_tick = (r.m_cnt == CNT_ZERO);
    assign m_rs_req = m_addr_wr_i || (m_cmd_wr_i && m_cmd_i == CMD_REPSTART);
    assign m_new_addr = m_addr_wr_i ? m_addr_i : r.m_addr;
    assign s_match = addr_match(r.s_sh, s_own_addr_i, s_gen_call_en_i, s_addr_recog_en_i);

    always_comb begin
        n = r;
        m_go = 1'h0;
        n.scl_s1 = scl_i;
        n.scl_s2 = r.scl_s1;
        n.scl_d = r.scl_s2;
        n.sda_s1 = sda_i;
        n.sda_s2 = r.sda_s1;
        n.sda_d = r.sda_s2;
        if (start_det) begin
            n.bus_busy = 1'h1;
        end
        if (stop_det) begin
            n.bus_busy = 1'h0;
        end

        // master half-bit timer, reloaded while idle, held or stretched
        if (r.m_state inside {MS_IDLE, MS_WAIT_IDLE, MS_HOLD, MS_LOST} ||
            (r.m_state inside {MS_HIGH, MS_RS_HIGH, MS_STOP_HIGH} && !r.scl_s2)) begin
            n.m_cnt = HALF_LOAD;
        end else begin
            n.m_cnt = m_tick ? HALF_LOAD : r.m_cnt - CNT_ONE;
        end
        if (m_flag_clr_i) begin
            n.m_rif = 1'h0;
            n.m_wif = 1'h0;
            n.m_arb = 1'h0;
            n.m_berr = 1'h0;
        end
        if ((r.m_state == MS_IDLE && m_addr_wr_i) || (r.m_state == MS_HOLD && m_rs_req)) begin
            n.m_addr = m_new_addr;
            n.m_sh = m_new_addr;
            n.m_dir = m_new_addr[0];
            n.m_quick = quick_command_enable_i;
            n.m_wr = 1'h1;
            n.m_addr_ph = 1'h1;
            n.m_after_stop = 1'h0;
        end

        if ((start_det || stop_det) && r.m_state inside {MS_LOW, MS_HIGH}) begin
            n.m_wif = 1'h1;
            n.m_arb = 1'h1;
            n.m_berr = 1'h1;
            n.m_state = MS_LOST;
        end else begin
            unique case (r.m_state)
                MS_IDLE: begin
                    if (m_addr_wr_i) begin
                        n.m_state = r.bus_busy ? MS_WAIT_IDLE : MS_START;
                    end
                end
                MS_WAIT_IDLE: begin
                    if (!r.bus_busy) begin
                        n.m_state = MS_START;
                    end
                end
                MS_START: begin
                    if (m_tick) begin
                        n.m_state = MS_LOW;
                        n.m_bit = BIT_FIRST;
                    end
                end
                MS_LOW: begin
                    if (m_tick) begin
                        n.m_state = MS_HIGH;
                    end
                end
                MS_HIGH: begin
                    if (m_tick) begin
                        n.m_state = MS_LOW;
                        n.m_bit = r.m_bit + BIT_ONE;
                        if (r.m_bit != BIT_ACK) begin
                            n.m_sh = {r.m_sh[6:0], r.sda_s2};
                        end
                        if (r.m_wr && r.m_bit != BIT_ACK && r.m_sh[7] && !r.sda_s2) begin
                            n.m_wif = 1'h1;
                            n.m_arb = 1'h1;
                            n.m_state = MS_LOST;
                        end else if (!r.m_wr && r.m_bit == BIT_LAST) begin
                            n.m_data = {r.m_sh[6:0], r.sda_s2};
                            n.m_rif = 1'h1;
                            n.m_received_ack_flag = 1'h0;
                            n.m_state = MS_HOLD;
                        end else if (r.m_bit == BIT_ACK) begin
                            n.m_bit = BIT_FIRST;
                            if (!r.m_wr) begin
                                if (r.m_after_stop) begin
                                    n.m_state = MS_STOP_LOW;
                                end
                            end else begin
                                n.m_received_ack_flag = r.sda_s2;
                                n.m_addr_ph = 1'h0;
                                if (r.m_addr_ph && !r.sda_s2 && r.m_dir && r.m_quick) begin
                                    n.m_rif = 1'h1;
                                    n.m_state = MS_HOLD;
                                end else if (r.m_addr_ph && !r.sda_s2 && r.m_dir) begin
                                    n.m_wr = 1'h0;
                                end else begin
                                    n.m_wif = 1'h1;
                                    n.m_state = MS_HOLD;
                                end
                            end
                        end
                    end
                end
                MS_HOLD: begin
                    if (m_rs_req) begin
                        m_go = 1'h1;
                        n.m_state = MS_RS_LOW;
                    end else if (m_data_wr_i && r.m_wr) begin
                        m_go = 1'h1;
                        n.m_sh = m_data_i;
                        n.m_bit = BIT_FIRST;
                        n.m_state = MS_LOW;
                    end else if (m_cmd_wr_i && m_cmd_i == CMD_STOP) begin
                        m_go = 1'h1;
                        if (!r.m_wr) begin
                            n.m_ack_bit = acknowledge_action_i;
                            n.m_bit = BIT_ACK;
                            n.m_after_stop = 1'h1;
                            n.m_state = MS_LOW;
                        end else begin
                            n.m_state = MS_STOP_LOW;
                        end
                    end else if (!r.m_wr && ((m_cmd_wr_i && m_cmd_i == CMD_RECV) ||
                                 (m_data_rd_i && smart_mode_enable_i && r.m_rif &&
                                  acknowledge_action_i == ACK_LVL))) begin
                        m_go = 1'h1;
                        n.m_ack_bit = acknowledge_action_i;
                        n.m_bit = BIT_ACK;
                        n.m_after_stop = 1'h0;
                        n.m_state = MS_LOW;
                    end
                end
                MS_RS_LOW: begin
                    if (m_tick) begin
                        n.m_state = MS_RS_HIGH;
                    end
                end
                MS_RS_HIGH: begin
                    if (m_tick) begin
                        n.m_state = MS_START;
                    end
                end
                MS_STOP_LOW: begin
                    if (m_tick) begin
                        n.m_state = MS_STOP_HIGH;
                    end
                end
                MS_STOP_HIGH: begin
                    if (m_tick) begin
                        n.m_state = MS_IDLE;
                    end
                end
                MS_LOST: begin
                    if (!r.bus_busy) begin
                        n.m_state = MS_IDLE;
                    end
                end
                default: begin
                    n.m_state = MS_IDLE;
                end
            endcase
        end
        if (m_go) begin
            n.m_rif = 1'h0;
            n.m_wif = 1'h0;
        end
        if (!master_enable_i) begin
            n.m_state = MS_IDLE;
        end

        // slave
        if (s_data_flag_clr_i || (s_smart_mode_enable_i && (s_data_rd_i || s_data_wr_i))) begin
            n.s_dif = 1'h0;
        end
        if (s_addr_stop_flag_clr_i) begin
            n.s_slave_addr_stop_flag = 1'h0;
        end
        if (s_err_clr_i) begin
            n.s_coll = 1'h0;
            n.s_berr = 1'h0;
        end
        if (s_data_wr_i) begin
            n.s_data = s_data_i;
        end
        if (scl_fall) begin
            n.s_just_start = 1'h0;
        end
        if (!slave_enable_i) begin
            n.s_state = SS_IDLE;
            n.s_active = 1'h0;
        end else if (start_det) begin
            n.s_state = SS_ADDR;
            n.s_bit = BIT_FIRST;
            n.s_just_start = 1'h1;
        end else if (stop_det) begin
            if (r.s_just_start) begin
                n.s_berr = 1'h1;
            end
            if (r.s_active) begin
                n.s_slave_addr_stop_flag = 1'h1;
                n.s_ap = 1'h0;
            end
            n.s_active = 1'h0;
            n.s_state = SS_IDLE;
        end else begin
            unique case (r.s_state)
                SS_IDLE: begin
                end
                SS_ADDR, SS_RX: begin
                    if (scl_rise) begin
                        n.s_sh = {r.s_sh[6:0], r.sda_s2};
                        n.s_bit = r.s_bit + BIT_ONE;
                    end else if (scl_fall && r.s_bit == BIT_ACK) begin
                        n.s_state = SS_HOLD;
                        if (r.s_state == SS_RX) begin
                            n.s_data = r.s_sh;
                            n.s_dif = 1'h1;
                            n.s_resume = RES_RECEIVED_ACK_FLAG;
                        end else if (s_match) begin
                            n.s_data = r.s_sh;
                            n.s_dir = r.s_sh[0];
                            n.s_ap = 1'h1;
                            n.s_slave_addr_stop_flag = 1'h1;
                            n.s_active = 1'h1;
                            n.s_resume = RES_ADDR;
                        end else begin
                            n.s_state = SS_IDLE;
                        end
                    end
                end
                SS_HOLD: begin
                    if (!r.s_dif && !r.s_slave_addr_stop_flag) begin
                        if (r.s_resume == RES_TX) begin
                            n.s_sh = r.s_data;
                            n.s_bit = BIT_FIRST;
                            n.s_state = SS_TX;
                        end else begin
                            n.s_ack_bit = s_acknowledge_action_i;
                            n.s_state = SS_ACK;
                        end
                    end
                end
                SS_ACK: begin
                    if (scl_rise && r.s_ack_bit == NACK_LVL && !r.sda_s2) begin
                        n.s_coll = 1'h1;
                        n.s_state = SS_IDLE;
                    end else if (scl_fall) begin
                        n.s_bit = BIT_FIRST;
                        if (r.s_ack_bit == NACK_LVL) begin
                            n.s_state = SS_IDLE;
                        end else if (r.s_resume == RES_ADDR && r.s_dir) begin
                            n.s_dif = 1'h1;
                            n.s_resume = RES_TX;
                            n.s_state = SS_HOLD;
                        end else begin
                            n.s_state = SS_RX;
                        end
                    end
                end
                SS_TX: begin
                    if (scl_rise && r.s_sh[7] && !r.sda_s2) begin
                        n.s_coll = 1'h1;
                        n.s_state = SS_IDLE;
                    end else if (scl_rise) begin
                        n.s_bit = r.s_bit + BIT_ONE;
                    end else if (scl_fall) begin
                        n.s_sh = {r.s_sh[6:0], 1'h1};
                        if (r.s_bit == BIT_ACK) begin
                            n.s_state = SS_TXACK;
                        end
                    end
                end
                SS_TXACK: begin
                    if (scl_rise) begin
                        n.s_received_ack_flag = r.sda_s2;
                    end else if (scl_fall) begin
                        n.s_dif = 1'h1;
                        n.s_resume = RES_TX;
                        n.s_state = (r.s_received_ack_flag == NACK_LVL) ? SS_IDLE : SS_HOLD;
                    end
                end
                default: begin
                    n.s_state = SS_IDLE;
                end
            endcase
        end

        // pin drive, registered
        n.scl_lo = (n.m_state inside {MS_LOW, MS_RS_LOW, MS_STOP_LOW}) ||
                   (n.m_state == MS_HOLD && (n.m_rif || n.m_wif)) ||
                   (n.s_state == SS_HOLD);
        n.sda_lo = (n.m_state inside {MS_START, MS_STOP_LOW, MS_STOP_HIGH}) ||
                   (n.m_state inside {MS_LOW, MS_HIGH} && m_drives(n.m_bit, n.m_wr) &&
                    !m_cur_bit(n.m_bit, n.m_sh, n.m_ack_bit)) ||
                   (n.s_state == SS_ACK && n.s_ack_bit == ACK_LVL) ||
                   (n.s_state == SS_TX && !n.s_sh[7]);
        n.irq_vec = (n.s_dif || n.s_slave_addr_stop_flag) ? VEC_SLAVE : VEC_MASTER;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign scl_o = 1'h0;
    assign sda_o = 1'h0;
    assign scl_oe_o = r.scl_lo;
    assign sda_oe_o = r.sda_lo;
    assign master_data_o = r.m_data;
    assign master_read_flag_o = r.m_rif;
    assign master_write_flag_o = r.m_wif;
    assign arbitration_lost_flag_o = r.m_arb;
    assign bus_error_flag_o = r.m_berr;
    assign received_ack_flag_o = r.m_received_ack_flag;
    assign bus_busy_o = r.bus_busy;
    assign slave_data_o = r.s_data;
    assign slave_data_flag_o = r.s_dif;
    assign slave_addr_stop_flag_o = r.s_slave_addr_stop_flag;
    assign s_addr_not_stop_o = r.s_ap;
    assign s_dir_o = r.s_dir;
    assign s_collision_o = r.s_coll;
    assign s_bus_error_o = r.s_berr;
    assign s_received_ack_o = r.s_received_ack_flag;
    assign slave_irq_o = r.s_dif | r.s_slave_addr_stop_flag;
    assign master_irq_o = r.m_rif | r.m_wif;
    assign irq_vector_o = r.irq_vec;
endmodule : ims_top
`default_nettype wire

// ===== sim/ims_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ims_chk
    import ims_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic scl_oe_o,
    input wire logic m_flag_clr_i,
    input wire logic master_irq_o,
    input wire logic slave_irq_o,
    input wire logic master_read_flag_o,
    input wire logic master_write_flag_o,
    input wire logic arbitration_lost_flag_o,
    input wire logic received_ack_flag_o,
    input wire logic slave_data_flag_o,
    input wire logic slave_addr_stop_flag_o,
    input wire logic s_addr_not_stop_o,
    input wire logic s_addr_recog_en_i,
    input wire logic s_gen_call_en_i,
    input wire logic [6:0] s_own_addr_i,
    input wire logic [7:0] slave_data_o,
    input wire logic [7:0] irq_vector_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sirq_or_a:
    assert property (slave_irq_o == (slave_data_flag_o | slave_addr_stop_flag_o))
        else $error("slave request not or of flags");
    mirq_or_a:
    assert property (master_irq_o == (master_read_flag_o | master_write_flag_o))
        else $error("master request not or of flags");
    svec_sel_a:
    assert property (slave_irq_o [*2] |-> irq_vector_o == VEC_SLAVE)
        else $error("slave vector offset wrong");
    mflag_hold_a:
    assert property ($rose(master_irq_o) && !arbitration_lost_flag_o |-> ##[0:2] scl_oe_o)
        else $error("master flag without clock hold");
    nack_flag_a:
    assert property ($rose(received_ack_flag_o) |-> ##[0:1] master_write_flag_o)
        else $error("nack without write flag");
    mclr_rel_a:
    assert property (m_flag_clr_i && master_irq_o && !slave_irq_o |-> ##[1:3] !scl_oe_o)
        else $error("clock not released after clear");
    saddr_match_a:
    assert property ($rose(slave_addr_stop_flag_o) && s_addr_not_stop_o && !s_addr_recog_en_i
        |-> slave_data_o[7:1] == s_own_addr_i || s_gen_call_en_i) else $error("address mismatch");
    saddr_hold_a:
    assert property ($rose(slave_addr_stop_flag_o) && s_addr_not_stop_o |-> ##[0:2] scl_oe_o)
        else $error("slave match without clock hold");
    cover property ($rose(master_read_flag_o));
    cover property ($rose(master_write_flag_o) && received_ack_flag_o);
    cover property ($rose(slave_addr_stop_flag_o) && !s_addr_not_stop_o);
endmodule : ims_chk
bind ims_top ims_chk i_ims_chk (.*);
`default_nettype wire

// ===== sim/ims_peer.sv
`timescale 1ns/100ps
`default_nettype none
module ims_peer #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic ack_en_i,
    input wire logic [7:0] tx_i,
    output var logic sda_oe_o
);
    logic [7:0] rx_reg;
    initial forever begin : frame
        sda_oe_o = 1'b0;
        @(negedge sda_i iff scl_i);
        repeat (8) @(posedge scl_i) rx_reg = {rx_reg[6:0], sda_i};
        @(negedge scl_i);
        sda_oe_o = ack_en_i && rx_reg[7:1] == ADDR;
        if (sda_oe_o && rx_reg[0]) begin
            for (int i = 7; i >= 0; i--) begin
                @(negedge scl_i);
                sda_oe_o = !tx_i[i];
            end
        end
        @(negedge scl_i);
        sda_oe_o = 1'b0;
    end
    // stop ends any frame
    always @(posedge sda_i) if (scl_i) disable frame;
endmodule : ims_peer
`default_nettype wire

// ===== sim/ims_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module ims_top_tb;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic ref_clk_i, rst_i = 1, master_enable_i = 1, quick_command_enable_i = 0, ack_en = 1;
    logic smart_mode_enable_i = 0, acknowledge_action_i = 0, m_addr_wr_i = 0, m_data_wr_i = 0;
    logic m_data_rd_i = 0, m_cmd_wr_i = 0, m_flag_clr_i = 0, slave_enable_i = 1;
    logic s_gen_call_en_i = 0, s_addr_recog_en_i = 0, s_smart_mode_enable_i = 0;
    logic s_acknowledge_action_i = 0, s_data_wr_i = 0, s_data_rd_i = 0, s_data_flag_clr_i = 0;
    logic s_addr_stop_flag_clr_i = 0, s_err_clr_i = 0;
    logic [7:0] m_addr_i = 8'h00, m_data_i = 8'h00, s_data_i = 8'h00;
    logic [1:0] m_cmd_i = 2'h0;
    logic [6:0] s_own_addr_i = 7'h35;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, master_read_flag_o, master_write_flag_o, p_oe;
    logic arbitration_lost_flag_o, bus_error_flag_o, received_ack_flag_o, bus_busy_o;
    logic slave_data_flag_o, slave_addr_stop_flag_o, s_addr_not_stop_o, s_dir_o, s_collision_o;
    logic s_bus_error_o, s_received_ack_o, slave_irq_o, master_irq_o;
    logic [7:0] master_data_o, slave_data_o, irq_vector_o;
    wire scl_i = !scl_oe_o;
    wire sda_i = !(sda_oe_o || p_oe);
    wire [3:0] fl = {!bus_busy_o, slave_addr_stop_flag_o, master_read_flag_o, master_write_flag_o};
    ims_top #(.HALF_CYC(20)) i_ims_top (.*);
    ims_peer i_ims_peer (.scl_i(scl_i), .sda_i(sda_i), .ack_en_i(ack_en), .tx_i(8'ha5),
        .sda_oe_o(p_oe));
    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic final_report;
        if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    task automatic wt(input int k);
        int n = 0;
        while (fl[k] !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_i);
            n++;
        end
        repeat (2) @(negedge ref_clk_i);
        if (n >= 4000) begin
            n_mismatch++;
            final_report();
        end
    endtask : wt
    task automatic req(input logic [3:0] v, input logic [7:0] a);
        {m_addr_wr_i, m_cmd_wr_i, m_flag_clr_i, s_addr_stop_flag_clr_i} = v;
        {s_data_flag_clr_i, s_err_clr_i} = {2{v[0]}};
        m_addr_i = a;
        m_cmd_i = a[1:0];
        @(negedge ref_clk_i);
        {m_addr_wr_i, m_cmd_wr_i, m_flag_clr_i, s_addr_stop_flag_clr_i} = 4'h0;
        {s_data_flag_clr_i, s_err_clr_i} = 2'h0;
    endtask : req
    initial begin
        repeat (12) @(negedge ref_clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        req(4'h8, 8'h54);
        wt(0);
        `CHK(received_ack_flag_o, 1'b0)
        `CHK(scl_oe_o, 1'b1)
        `CHK(irq_vector_o, 8'h02)
        `CHK(arbitration_lost_flag_o, 1'b0)
        `CHK(bus_error_flag_o, 1'b0)
        req(4'h2, 8'h00);
        repeat (3) @(negedge ref_clk_i);
        `CHK(scl_oe_o, 1'b0)
        req(4'h4, 8'h03);
        wt(3);
        ack_en = 1'b0;
        req(4'h8, 8'h54);
        wt(0);
        `CHK(received_ack_flag_o, 1'b1)
        `CHK(scl_oe_o, 1'b1)
        ack_en = 1'b1;
        req(4'h4, 8'h03);
        wt(3);
        req(4'h8, 8'h55);
        wt(1);
        `CHK(master_data_o, 8'ha5)
        `CHK(received_ack_flag_o, 1'b0)
        req(4'h4, 8'h03);
        wt(3);
        for (int k = 0; k < 2; k++) begin
            s_addr_recog_en_i = k[0];
            s_acknowledge_action_i = k[0];
            req(4'h8, k[0] ? 8'h22 : 8'h6a);
            wt(2);
            `CHK(slave_data_o, k[0] ? 8'h22 : 8'h6a)
            `CHK(s_addr_not_stop_o, 1'b1)
            `CHK(s_dir_o, 1'b0)
            `CHK(irq_vector_o, 8'h00)
            req(4'h1, 8'h00);
            wt(0);
            `CHK(received_ack_flag_o, k[0])
            req(4'h4, 8'h03);
            if (k == 0) begin
                wt(2);
                `CHK(s_addr_not_stop_o, 1'b0)
                `CHK(s_bus_error_o, 1'b0)
                `CHK(s_collision_o, 1'b0)
                req(4'h1, 8'h00);
            end
            wt(3);
        end
        s_addr_recog_en_i = 1'b0;
        quick_command_enable_i = 1'b1;
        for (int d = 0; d < 2; d++) begin
            req(4'h8, {7'h2a, d[0]});
            wt(d);
            `CHK(fl[1 - d], 1'b0)
            req(4'h4, 8'h03);
            wt(3);
        end
        final_report();
    end
endmodule : ims_top_tb
`default_nettype wire
